// ==== inc/flash_read_regs.vh ====
// Constants for the serial flash read path: opcodes, lane codes, counts.
`ifndef FLASH_READ_REGS_VH
`define FLASH_READ_REGS_VH

// ****************************************************************
// Protocol and lane codes (a lane code is log2 of the lines used)
// ****************************************************************
`define LANE_1          2'h0
`define LANE_2          2'h1
`define LANE_4          2'h2
`define PROTO_EXTENDED  2'h0
`define PROTO_DUAL      2'h1
`define PROTO_QUAD      2'h2

// ****************************************************************
// Single transfer rate read opcodes, 3-byte or mode-selected address
// ****************************************************************
`define OP_READ         8'h03
`define OP_FAST         8'h0B
`define OP_DUAL_OUT     8'h3B
`define OP_DUAL_IO      8'hBB
`define OP_DUAL_IO_X    8'hBB
`define OP_QUAD_OUT     8'h6B
`define OP_QUAD_IO      8'hEB
`define OP_WORD_READ    8'hE7

// ****************************************************************
// Double transfer rate read opcodes
// ****************************************************************
`define OP_DTR_FAST     8'h0D
`define OP_DTR_DUAL_OUT 8'h3D
`define OP_DTR_DUAL_IO  8'hBD
`define OP_DTR_QUAD_OUT 8'h6D
`define OP_DTR_QUAD_IO  8'hED

// ****************************************************************
// Dedicated 4-byte address opcodes
// ****************************************************************
`define OP4_READ        8'h13
`define OP4_FAST        8'h0C
`define OP4_DUAL_OUT    8'h3C
`define OP4_DUAL_IO     8'hBC
`define OP4_QUAD_OUT    8'h6C
`define OP4_QUAD_IO     8'hEC
`define OP4_DTR_FAST    8'h0E
`define OP4_DTR_DUAL_IO 8'hBE
`define OP4_DTR_QUAD_IO 8'hEE

// ****************************************************************
// Counts
// ****************************************************************
`define OPCODE_BITS     6'd8
`define ADDR_BITS_3B    6'd24
`define ADDR_BITS_4B    6'd32
`define WORD_DUMMY      4'h4
`define NO_DUMMY        4'h0
`define ADDR_MASK_3B    32'h00FFFFFF
`define RESET_ADDR      32'h00000000

`endif

// ==== rtl/serial_flash_read_path.v ====
// Read command path of a serial NOR flash, sampling the host serial clock.
//
// Contract
// - Host may end a read anytime by raising select; device stops at once.
// - Default address width is three bytes, bits 23 down to 0.
// - Decode single-rate reads 03h, 0Bh, 3Bh, BBh, 6Bh, EBh.
// - Decode double-rate reads 0Dh, 3Dh, BDh, 6Dh, EDh.
// - Data starts at the byte the host addressed.
// - At the top of the address range the read wraps to zero.
// - Address bits are captured on rising serial clock edges, and on both edges in double rate.
// - Address advances by one after each byte fetched from memory.
// - Double-rate opcodes always double rate; others only when enabled.
// - Word read E7h needs even address; device inserts exactly four dummies.
// - E7h accepted in extended and quad, ignored in dual and double rate.
// - Four-byte opcodes 13h, 0Ch, 3Ch, BCh, 6Ch, ECh take 32 address bits.
// - Decode four-byte double-rate reads 0Eh, BEh, EEh.
// - Address width from nonvolatile setting or enter/exit four-byte commands.
// - Four-byte opcodes always 32 bits; others follow configured mode.
// - Fast read dummy clock count follows the configured value.
`timescale 1ns/100ps
`include "flash_read_regs.vh"
module serial_flash_read_path (
  input  wire        clock,
  input  wire        rst,
  input  wire        cs_n,
  input  wire        sclk,
  input  wire [3:0]  serial_io_lines_in,
  output wire [3:0]  serial_io_lines_out,
  output wire [3:0]  serial_io_lines_oe,
  input  wire [1:0]  proto_sel,
  input  wire        dtr_cfg_en,
  input  wire        addr4_nv_cfg,
  input  wire        enter_addr4,
  input  wire        exit_addr4,
  input  wire [3:0]  dummy_cfg,
  output wire        mem_req_valid,
  input  wire        mem_req_ready,
  output wire [31:0] mem_req_addr,
  input  wire        mem_rdata_valid,
  output wire        mem_rdata_ready,
  input  wire [7:0]  mem_rdata,
  output wire        cmd_busy
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam ST_IDLE   = 3'h0;
  localparam ST_OPCODE = 3'h1;
  localparam ST_ADDR   = 3'h2;
  localparam ST_DUMMY  = 3'h3;
  localparam ST_DATA   = 3'h4;
  localparam ST_IGNORE = 3'h5;

  // ****************************************************************
  // Lane helpers
  // ****************************************************************
  function [5:0] lane_bits;
    input [1:0] c;
    begin
      case (c)
        `LANE_1: lane_bits = 6'd1;
        `LANE_2: lane_bits = 6'd2;
        default: lane_bits = 6'd4;
      endcase
    end
  endfunction

  // Higher line numbers carry the more significant bits of each group.
  function [31:0] shift_in;
    input [31:0] s;
    input [3:0]  d;
    input [1:0]  c;
    begin
      case (c)
        `LANE_1: shift_in = {s[30:0], d[0]};
        `LANE_2: shift_in = {s[29:0], d[1:0]};
        default: shift_in = {s[27:0], d};
      endcase
    end
  endfunction

  // Single-line data leaves on line 1, since line 0 is the host's input.
  function [3:0] place_unit;
    input [7:0] s;
    input [1:0] c;
    begin
      case (c)
        `LANE_1: place_unit = {2'b00, s[7], 1'b0};
        `LANE_2: place_unit = {2'b00, s[7:6]};
        default: place_unit = s[7:4];
      endcase
    end
  endfunction

  function [3:0] lane_mask;
    input [1:0] c;
    begin
      case (c)
        `LANE_1: lane_mask = 4'h2;
        `LANE_2: lane_mask = 4'h3;
        default: lane_mask = 4'hF;
      endcase
    end
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [2:0]  state_r;
  reg         sclk_r;
  reg  [31:0] cap_r;
  reg  [5:0]  cnt_r;
  reg  [1:0]  addr_lane_r;
  reg  [1:0]  data_lane_r;
  reg         dtr_r;
  reg  [5:0]  addr_bits_r;
  reg  [3:0]  dummy_r;
  reg  [31:0] addr_r;
  reg         fetch_r;
  reg         pend_r;
  reg  [7:0]  sh_r;
  reg  [3:0]  left_r;
  reg         go_r;
  reg  [3:0]  out_r;
  reg  [3:0]  oe_r;
  reg         addr4_r;
  reg         init_r;

  // ****************************************************************
  // Edge detection and datapath wires
  // ****************************************************************
  wire        rise;
  wire        fall;
  wire        cap_edge;
  wire        drive_edge;
  wire        drive_now;
  wire [31:0] op_shift;
  wire [31:0] addr_shift;
  wire [5:0]  op_cnt_nxt;
  wire [5:0]  addr_cnt_nxt;
  wire [31:0] addr_inc;
  wire        buf_in_ready;
  wire        buf_out_valid;
  wire        buf_out_ready;
  wire [7:0]  buf_out_data;
  wire [5:0]  data_w;

  // The serial clock is sampled; the host keeps each phase of it at least
  // two system clocks long so that no edge is missed.
  assign rise         = sclk & ~sclk_r;
  assign fall         = ~sclk & sclk_r;
  // The fall that closes the last opcode clock carries no address unit;
  // double-rate address capture starts on the following rise.
  assign cap_edge     = rise | (dtr_r & fall & (cnt_r != 6'h00));
  assign drive_edge   = fall | (dtr_r & rise);
  assign drive_now    = (state_r == ST_DATA) & (go_r ? drive_edge : fall);
  assign op_shift     = shift_in(cap_r, serial_io_lines_in, proto_sel);
  assign addr_shift   = shift_in(cap_r, serial_io_lines_in, addr_lane_r);
  assign op_cnt_nxt   = cnt_r + lane_bits(proto_sel);
  assign addr_cnt_nxt = cnt_r + lane_bits(addr_lane_r);
  assign data_w       = lane_bits(data_lane_r);
  assign addr_inc     = (addr_bits_r == `ADDR_BITS_4B) ? addr_r + 32'h1 :
                        ((addr_r + 32'h1) & `ADDR_MASK_3B);
  assign buf_out_ready = drive_now & (left_r == 4'h0);

  // ****************************************************************
  // Opcode decode
  // ****************************************************************
  reg        d_ok;
  reg        d_dtr_op;
  reg        d_four;
  reg [1:0]  d_al;
  reg [1:0]  d_dl;
  reg [3:0]  d_dummy;

  always @* begin
    d_ok     = 1'b1;
    d_dtr_op = 1'b0;
    d_four   = 1'b0;
    d_al     = `LANE_1;
    d_dl     = `LANE_1;
    d_dummy  = dummy_cfg;
    case (op_shift[7:0])
      `OP_READ: d_dummy = `NO_DUMMY;
      `OP_FAST: d_dl = `LANE_1;
      `OP_DUAL_OUT: d_dl = `LANE_2;
      `OP_DUAL_IO_X: begin
        d_al = `LANE_2;
        d_dl = `LANE_2;
      end
      `OP_QUAD_OUT: d_dl = `LANE_4;
      `OP_QUAD_IO: begin
        d_al = `LANE_4;
        d_dl = `LANE_4;
      end
      `OP_WORD_READ: begin
        d_al    = `LANE_4;
        d_dl    = `LANE_4;
        d_dummy = `WORD_DUMMY;
        d_ok    = (proto_sel != `PROTO_DUAL) & ~dtr_cfg_en;
      end
      `OP_DTR_FAST: d_dtr_op = 1'b1;
      `OP_DTR_DUAL_OUT: begin
        d_dtr_op = 1'b1;
        d_dl     = `LANE_2;
      end
      `OP_DTR_DUAL_IO: begin
        d_dtr_op = 1'b1;
        d_al     = `LANE_2;
        d_dl     = `LANE_2;
      end
      `OP_DTR_QUAD_OUT: begin
        d_dtr_op = 1'b1;
        d_dl     = `LANE_4;
      end
      `OP_DTR_QUAD_IO: begin
        d_dtr_op = 1'b1;
        d_al     = `LANE_4;
        d_dl     = `LANE_4;
      end
      `OP4_READ: begin
        d_four  = 1'b1;
        d_dummy = `NO_DUMMY;
      end
      `OP4_FAST: d_four = 1'b1;
      `OP4_DUAL_OUT: begin
        d_four = 1'b1;
        d_dl   = `LANE_2;
      end
      `OP4_DUAL_IO: begin
        d_four = 1'b1;
        d_al   = `LANE_2;
        d_dl   = `LANE_2;
      end
      `OP4_QUAD_OUT: begin
        d_four = 1'b1;
        d_dl   = `LANE_4;
      end
      `OP4_QUAD_IO: begin
        d_four = 1'b1;
        d_al   = `LANE_4;
        d_dl   = `LANE_4;
      end
      `OP4_DTR_FAST: begin
        d_four   = 1'b1;
        d_dtr_op = 1'b1;
      end
      `OP4_DTR_DUAL_IO: begin
        d_four   = 1'b1;
        d_dtr_op = 1'b1;
        d_al     = `LANE_2;
        d_dl     = `LANE_2;
      end
      `OP4_DTR_QUAD_IO: begin
        d_four   = 1'b1;
        d_dtr_op = 1'b1;
        d_al     = `LANE_4;
        d_dl     = `LANE_4;
      end
      default: d_ok = 1'b0;
    endcase
    // Dual and quad protocols put every phase on all of their lines.
    if (proto_sel == `PROTO_DUAL) begin
      d_al = `LANE_2;
      d_dl = `LANE_2;
    end else if (proto_sel == `PROTO_QUAD) begin
      d_al = `LANE_4;
      d_dl = `LANE_4;
    end
  end

  // ****************************************************************
  // Memory fetch: one request outstanding, drained into the buffer
  // ****************************************************************
  assign mem_req_valid   = fetch_r & ~pend_r;
  assign mem_req_addr    = addr_r;
  // A byte that comes back after an abort is taken and dropped.
  assign mem_rdata_ready = fetch_r ? buf_in_ready : 1'b1;

  two_entry_buffer u_buf (
    .clock     (clock),
    .rst       (rst),
    .flush     (cs_n),
    .in_valid  (mem_rdata_valid & fetch_r & pend_r),
    .in_ready  (buf_in_ready),
    .in_data   (mem_rdata),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      sclk_r      <= 1'b0;
      cap_r       <= 32'h00000000;
      cnt_r       <= 6'h00;
      addr_lane_r <= `LANE_1;
      data_lane_r <= `LANE_1;
      dtr_r       <= 1'b0;
      addr_bits_r <= `ADDR_BITS_3B;
      dummy_r     <= `NO_DUMMY;
      addr_r      <= `RESET_ADDR;
      fetch_r     <= 1'b0;
      pend_r      <= 1'b0;
      sh_r        <= 8'h00;
      left_r      <= 4'h0;
      go_r        <= 1'b0;
      out_r       <= 4'h0;
      oe_r        <= 4'h0;
      addr4_r     <= 1'b0;
      init_r      <= 1'b0;
    end else begin
      sclk_r <= sclk;
      // The nonvolatile width is caught on the first edge after reset.
      if (!init_r) begin
        init_r  <= 1'b1;
        addr4_r <= addr4_nv_cfg;
      end else if (enter_addr4) begin
        addr4_r <= 1'b1;
      end else if (exit_addr4) begin
        addr4_r <= 1'b0;
      end
      if (mem_req_valid & mem_req_ready) begin
        pend_r <= 1'b1;
        addr_r <= addr_inc;
      end else if (mem_rdata_valid & mem_rdata_ready) begin
        pend_r <= 1'b0;
      end
      if (cs_n) begin
        state_r <= ST_IDLE;
        fetch_r <= 1'b0;
        go_r    <= 1'b0;
        left_r  <= 4'h0;
        oe_r    <= 4'h0;
        dtr_r   <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            state_r <= ST_OPCODE;
            cnt_r   <= 6'h00;
            cap_r   <= 32'h00000000;
          end
          ST_OPCODE: begin
            if (rise) begin
              cap_r <= op_shift;
              cnt_r <= op_cnt_nxt;
              if (op_cnt_nxt == `OPCODE_BITS) begin
                cnt_r       <= 6'h00;
                addr_lane_r <= d_al;
                data_lane_r <= d_dl;
                dtr_r       <= d_dtr_op | dtr_cfg_en;
                dummy_r     <= d_dummy;
                addr_bits_r <= (d_four | addr4_r) ? `ADDR_BITS_4B :
                               `ADDR_BITS_3B;
                state_r     <= d_ok ? ST_ADDR : ST_IGNORE;
              end
            end
          end
          ST_ADDR: begin
            if (cap_edge) begin
              cap_r <= addr_shift;
              cnt_r <= addr_cnt_nxt;
              if (addr_cnt_nxt == addr_bits_r) begin
                cnt_r   <= 6'h00;
                addr_r  <= (addr_bits_r == `ADDR_BITS_4B) ? addr_shift :
                           (addr_shift & `ADDR_MASK_3B);
                fetch_r <= 1'b1;
                state_r <= (dummy_r == `NO_DUMMY) ? ST_DATA :
                           ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            if (rise) begin
              cnt_r <= cnt_r + 6'h01;
              if ((cnt_r + 6'h01) == {2'b00, dummy_r}) begin
                state_r <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (drive_now) begin
              if (left_r != 4'h0) begin
                out_r  <= place_unit(sh_r, data_lane_r);
                sh_r   <= sh_r << data_w;
                left_r <= left_r - data_w[3:0];
                go_r   <= 1'b1;
              end else if (buf_out_valid) begin
                // Without a byte in hand the lines hold their value.
                out_r  <= place_unit(buf_out_data, data_lane_r);
                sh_r   <= buf_out_data << data_w;
                left_r <= 4'h8 - data_w[3:0];
                oe_r   <= lane_mask(data_lane_r);
                go_r   <= 1'b1;
              end
            end
          end
          ST_IGNORE: state_r <= ST_IGNORE;
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  assign serial_io_lines_out = out_r;
  assign serial_io_lines_oe  = oe_r;
  assign cmd_busy            = (state_r != ST_IDLE);

endmodule // serial_flash_read_path

// ==== rtl/two_entry_buffer.v ====
// Two-entry valid/ready buffer between memory fetch and the serializer.
`timescale 1ns/100ps
module two_entry_buffer (
  input  wire       clock,
  input  wire       rst,
  input  wire       flush,
  input  wire       in_valid,
  output wire       in_ready,
  input  wire [7:0] in_data,
  output wire       out_valid,
  input  wire       out_ready,
  output wire [7:0] out_data
);

  reg  [7:0] slot_r [0:1];
  reg        wr_ptr_r;
  reg        rd_ptr_r;
  reg  [1:0] count_r;
  wire       push;
  wire       pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = slot_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Flush wins over a push in the same cycle, so nothing of an aborted
  // read can leak into the next one.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_r   <= 1'b0;
      rd_ptr_r   <= 1'b0;
      count_r    <= 2'h0;
      slot_r[0]  <= 8'h00;
      slot_r[1]  <= 8'h00;
    end else if (flush) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (push) begin
        slot_r[wr_ptr_r] <= in_data;
        wr_ptr_r         <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push & ~pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop & ~push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule // two_entry_buffer

// ==== tb/flash_read_properties.sv ====
// Concurrent checks on the ports of the serial flash read path.
`timescale 1ns/100ps
module flash_read_properties (
  input wire        clock,
  input wire        rst,
  input wire        cs_n,
  input wire        sclk,
  input wire [3:0]  serial_io_lines_out,
  input wire [3:0]  serial_io_lines_oe,
  input wire        mem_req_valid,
  input wire        mem_req_ready,
  input wire [31:0] mem_req_addr,
  input wire        mem_rdata_ready,
  input wire        cmd_busy
);
  reg       sclk_q_r;
  reg [2:0] since_edge_r;

  // Output units may only move shortly after a serial clock edge.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_q_r     <= 1'b0;
      since_edge_r <= 3'h7;
    end else begin
      sclk_q_r <= sclk;
      if (sclk != sclk_q_r)
        since_edge_r <= 3'h0;
      else if (since_edge_r != 3'h7)
        since_edge_r <= since_edge_r + 3'h1;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_select;  $fell(cs_n); endsequence
  sequence s_release; $rose(cs_n); endsequence
  sequence s_accept;  mem_req_valid && mem_req_ready; endsequence

  chk_start_busy: assert property (s_select |=> cmd_busy)
    else $error("busy did not rise after select");
  chk_abort_oe: assert property (s_release |=> serial_io_lines_oe == 4'h0)
    else $error("lines still driven after deselect");
  chk_abort_busy: assert property (s_release |=> !cmd_busy)
    else $error("busy still high after deselect");
  chk_idle_quiet: assert property (cs_n [*3] |-> !mem_req_valid && mem_rdata_ready)
    else $error("memory side active while deselected");
  chk_addr_step: assert property (s_accept ##0 !cs_n |=>
      mem_req_addr == $past(mem_req_addr) + 32'h1 || mem_req_addr == 32'h0)
    else $error("fetch address did not advance by one");
  chk_one_out: assert property (s_accept |=> !mem_req_valid)
    else $error("second fetch issued while one outstanding");
  chk_oe_lanes: assert property (serial_io_lines_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("illegal line enable pattern");
  chk_oe_stands: assert property ((|serial_io_lines_oe) && !cs_n |=>
      serial_io_lines_oe == $past(serial_io_lines_oe))
    else $error("line enable changed while selected");
  chk_out_edge: assert property ($changed(serial_io_lines_out) && !cs_n &&
      !$past(cs_n) |-> since_edge_r <= 3'h4)
    else $error("output unit moved away from a clock edge");
  chk_busy_idle: assert property (!cmd_busy |-> serial_io_lines_oe == 4'h0)
    else $error("lines driven while idle");
endmodule // flash_read_properties

bind serial_flash_read_path flash_read_properties u_props (
  .clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk),
  .serial_io_lines_out(serial_io_lines_out),
  .serial_io_lines_oe(serial_io_lines_oe), .mem_req_valid(mem_req_valid),
  .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
  .mem_rdata_ready(mem_rdata_ready), .cmd_busy(cmd_busy));

// ==== tb/spi_host_model.sv ====
// Host side of the serial link: select, serial clock and line drive.
`timescale 1ns/100ps
module spi_host_model (
  input  wire       clock,
  input  wire [3:0] io_wire,
  output reg        cs_n,
  output reg        sclk,
  output reg  [3:0] host_lines
);
  initial begin
    cs_n       = 1'b1;
    sclk       = 1'b0;
    host_lines = 4'h0;
  end

  // Four system clocks a phase, twice the minimum the sampler needs.
  task half;
    begin
      repeat (4) @(negedge clock);
    end
  endtask

  task shift_out(input [31:0] v, input integer n, input integer w,
                 input dtr);
    integer    i;
    reg [31:0] t;
    begin
      for (i = n - w; i >= 0; i = i - w) begin
        t = (v >> i) & ((32'h1 << w) - 32'h1);
        host_lines = t[3:0];
        half;
        sclk = ~sclk;
        half;
        if (!dtr) sclk = 1'b0;
      end
    end
  endtask

  // Released lines toggle so that a stale value is never mistaken for data.
  task read_cmd(input [7:0] op, input integer ow, input [31:0] a,
                input integer an, input integer aw, input dtr,
                input integer dum, input integer dw, input integer nu,
                output [31:0] got);
    integer   k;
    reg [3:0] s;
    begin
      got = 32'h0;
      cs_n = 1'b0;
      half;
      shift_out({24'h0, op}, 8, ow, 1'b0);
      shift_out(a, an, aw, dtr);
      for (k = 0; k < dum; k = k + 1) begin
        host_lines = ~host_lines;
        half;
        sclk = 1'b1;
        half;
        sclk = 1'b0;
      end
      for (k = 0; k < nu; k = k + 1) begin
        host_lines = ~host_lines;
        half;
        s = (dw == 1) ? {3'h0, io_wire[1]} :
            (dw == 2) ? {2'h0, io_wire[1:0]} : io_wire;
        got = (got << dw) | {28'h0, s};
        sclk = ~sclk;
        if (!dtr) begin
          half;
          sclk = 1'b0;
        end
      end
      half;
      cs_n = 1'b1;
      sclk = 1'b0;
      half;
    end
  endtask
endmodule // spi_host_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the serial flash read path.
`timescale 1ns/100ps
`include "flash_read_regs.vh"
module tb_top;
  reg         clock, rst, dtr_cfg_en, addr4_nv_cfg, enter_addr4, exit_addr4;
  reg         mem_req_ready, mem_rdata_valid, oe_seen;
  reg  [1:0]  proto_sel;
  reg  [3:0]  dummy_cfg;
  reg  [7:0]  mem_rdata;
  reg  [31:0] base;
  wire        cs_n, sclk, mem_req_valid, mem_rdata_ready, cmd_busy;
  wire [3:0]  host_lines, dout, oe, io_wire;
  wire [31:0] mem_req_addr;
  integer     mismatches, checks_done;

  assign io_wire = (oe & dout) | (~oe & host_lines);

  serial_flash_read_path dut (
    .clock(clock), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .serial_io_lines_in(io_wire), .serial_io_lines_out(dout),
    .serial_io_lines_oe(oe), .proto_sel(proto_sel),
    .dtr_cfg_en(dtr_cfg_en), .addr4_nv_cfg(addr4_nv_cfg),
    .enter_addr4(enter_addr4), .exit_addr4(exit_addr4),
    .dummy_cfg(dummy_cfg), .mem_req_valid(mem_req_valid),
    .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
    .mem_rdata_valid(mem_rdata_valid), .mem_rdata_ready(mem_rdata_ready),
    .mem_rdata(mem_rdata), .cmd_busy(cmd_busy));

  spi_host_model host (.clock(clock), .io_wire(io_wire), .cs_n(cs_n),
    .sclk(sclk), .host_lines(host_lines));

  function [7:0] fdat(input [31:0] a);
    fdat = a[31:24] ^ a[23:16] ^ a[15:8] ^ a[7:0] ^ 8'h5A;
  endfunction

  // Memory answers one cycle after each accepted request.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_rdata_valid <= 1'b0;
      mem_rdata       <= 8'h00;
    end else if (mem_req_valid && mem_req_ready) begin
      mem_rdata_valid <= 1'b1;
      mem_rdata       <= fdat(mem_req_addr);
    end else if (mem_rdata_valid && mem_rdata_ready)
      mem_rdata_valid <= 1'b0;
  end

  always @(posedge clock) if (|oe) oe_seen <= 1'b1;

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task check(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task report_and_stop;
    begin
      if (mismatches == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task op_row(input [7:0] op, input [1:0] pr, input cd, input four,
              input dt, input ign, input [1:0] awc, input [1:0] dwc,
              input [1:0] dk);
    integer    dum;
    reg [31:0] got;
    begin
      base = base + 32'h00010010;
      dum = (dk == 2'h0) ? 0 : (dk == 2'h1) ? dummy_cfg : 4;
      @(negedge clock);
      proto_sel = pr;
      dtr_cfg_en = cd;
      oe_seen = 1'b0;
      host.read_cmd(op, 1 << pr, base, four ? 32 : 24, 1 << awc, dt, dum,
                    1 << dwc, 16 >> dwc, got);
      if (ign) check({31'h0, oe_seen}, 32'h0);
      else check(got, {16'h0, fdat(base), fdat(base + 32'h1)});
    end
  endtask

  task t_opcodes;
    begin
      op_row(`OP_READ,         0, 0, 0, 0, 0, 0, 0, 0);
      op_row(`OP_FAST,         0, 0, 0, 0, 0, 0, 0, 1);
      op_row(`OP_DUAL_OUT,     0, 0, 0, 0, 0, 0, 1, 1);
      op_row(`OP_DUAL_IO_X,    0, 0, 0, 0, 0, 1, 1, 1);
      op_row(`OP_QUAD_OUT,     0, 0, 0, 0, 0, 0, 2, 1);
      op_row(`OP_QUAD_IO,      0, 0, 0, 0, 0, 2, 2, 1);
      op_row(`OP_DTR_FAST,     0, 0, 0, 1, 0, 0, 0, 1);
      op_row(`OP_DTR_DUAL_OUT, 0, 0, 0, 1, 0, 0, 1, 1);
      op_row(`OP_DTR_DUAL_IO,  0, 0, 0, 1, 0, 1, 1, 1);
      op_row(`OP_DTR_QUAD_OUT, 0, 0, 0, 1, 0, 0, 2, 1);
      op_row(`OP_DTR_QUAD_IO,  0, 0, 0, 1, 0, 2, 2, 1);
      op_row(`OP4_READ,        0, 0, 1, 0, 0, 0, 0, 0);
      op_row(`OP4_FAST,        0, 0, 1, 0, 0, 0, 0, 1);
      op_row(`OP4_DUAL_OUT,    0, 0, 1, 0, 0, 0, 1, 1);
      op_row(`OP4_DUAL_IO,     0, 0, 1, 0, 0, 1, 1, 1);
      op_row(`OP4_QUAD_OUT,    0, 0, 1, 0, 0, 0, 2, 1);
      op_row(`OP4_QUAD_IO,     0, 0, 1, 0, 0, 2, 2, 1);
      op_row(`OP4_DTR_FAST,    0, 0, 1, 1, 0, 0, 0, 1);
      op_row(`OP4_DTR_DUAL_IO, 0, 0, 1, 1, 0, 1, 1, 1);
      op_row(`OP4_DTR_QUAD_IO, 0, 0, 1, 1, 0, 2, 2, 1);
      op_row(`OP_WORD_READ,    0, 0, 0, 0, 0, 2, 2, 2);
      op_row(`OP_WORD_READ,    2, 0, 0, 0, 0, 2, 2, 2);
      op_row(`OP_WORD_READ,    1, 0, 0, 0, 1, 1, 1, 2);
      op_row(`OP_WORD_READ,    0, 1, 0, 0, 1, 2, 2, 2);
      op_row(`OP_FAST,         0, 1, 0, 1, 0, 0, 0, 1);
      op_row(`OP_FAST,         1, 0, 0, 0, 0, 1, 1, 1);
      op_row(`OP_DTR_QUAD_IO,  2, 0, 0, 1, 0, 2, 2, 1);
    end
  endtask

  task t_wrap_abort;
    reg [31:0] got;
    begin
      @(negedge clock);
      proto_sel = 2'h0;
      dtr_cfg_en = 1'b0;
      host.read_cmd(`OP_FAST, 1, 32'h00FFFFFF, 24, 1, 1'b0, 2, 1, 16, got);
      check(got, {16'h0, fdat(32'h00FFFFFF), fdat(32'h0)});
      host.read_cmd(`OP4_READ, 1, 32'hFFFFFFFF, 32, 1, 1'b0, 0, 1, 16, got);
      check(got, {16'h0, fdat(32'hFFFFFFFF), fdat(32'h0)});
      host.read_cmd(`OP_READ, 1, 32'h80, 24, 1, 1'b0, 0, 1, 12, got);
      check(got, {16'h0, fdat(32'h80), fdat(32'h81)} >> 4);
      check({31'h0, cmd_busy}, 32'h0);
      host.read_cmd(`OP_READ, 1, 32'h0, 8, 1, 1'b0, 0, 1, 0, got);
      check({31'h0, cmd_busy}, 32'h0);
      @(negedge clock);
      enter_addr4 = 1'b1;
      @(negedge clock);
      enter_addr4 = 1'b0;
      host.read_cmd(`OP_FAST, 1, 32'h01000020, 32, 1, 1'b0, 2, 1, 16, got);
      check(got, {16'h0, fdat(32'h01000020), fdat(32'h01000021)});
      exit_addr4 = 1'b1;
      @(negedge clock);
      exit_addr4 = 1'b0;
      host.read_cmd(`OP_FAST, 1, 32'h00000040, 24, 1, 1'b0, 2, 1, 16, got);
      check(got, {16'h0, fdat(32'h40), fdat(32'h41)});
      // A reset in mid-run reloads the width from the nonvolatile setting.
      addr4_nv_cfg = 1'b1;
      dummy_cfg = 4'h5;
      rst = 1'b1;
      @(negedge clock);
      rst = 1'b0;
      repeat (2) @(negedge clock);
      host.read_cmd(`OP_FAST, 1, 32'h02000080, 32, 1, 1'b0, 5, 1, 16, got);
      check(got, {16'h0, fdat(32'h02000080), fdat(32'h02000081)});
    end
  endtask

  initial begin
    rst = 1'b1;
    {dtr_cfg_en, addr4_nv_cfg, enter_addr4, exit_addr4} = 4'h0;
    mem_req_ready = 1'b1;
    oe_seen = 1'b0;
    proto_sel = 2'h0;
    dummy_cfg = 4'h2;
    base = 32'h00000100;
    mismatches = 0;
    checks_done = 0;
    repeat (10) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
    t_opcodes;
    t_wrap_abort;
    report_and_stop;
  end

  // Watchdog well beyond the roughly 10500 cycles the tests need.
  initial begin
    #3000000;
    mismatches = mismatches + 1;
    report_and_stop;
  end
endmodule // tb_top
